// *** src/mcs_pkg.sv ***
// Constants shared by the management station and its serial frame engine
// How it works
// - Opcode zero sends an address frame
// - Go bit starts frame, clears when done
// - Opcode three reads previously addressed register
// - Read data returns in command data field
// - Polling yields to commands and pin mode
// - Pin-toggle mode locks out command register
// - Internal blocks sit at 16-register strides
// - Mode bit one picks long or short poll frames; commands stay long
// - Clock is core over two times divider+1
// - Start, opcode and turnaround codes per frame
package mcs_pkg;
  // Register offsets
  localparam logic [19:0] MCS_OFF_MODE    = 20'h000B4;
  localparam logic [19:0] MCS_OFF_COMMAND = 20'h000AC;
  localparam logic [19:0] MCS_OFF_MMDSEL  = 20'h1033C;
  localparam logic [19:0] MCS_OFF_POLL    = 20'h000B8;
  // Mode register fields
  localparam int          MCS_MODE_C45_BIT   = 31;
  localparam int          MCS_MODE_DIV_LSB   = 16;
  localparam int          MCS_MODE_MDC_BIT   = 11;
  localparam int          MCS_MODE_OE_BIT    = 10;
  localparam int          MCS_MODE_IO_BIT    = 9;
  localparam int          MCS_MODE_BANG_BIT  = 8;
  localparam int          MCS_MODE_POLL_BIT  = 4;
  localparam logic [5:0]  MCS_DIV_RST        = 6'h13;
  // Command register fields
  localparam int          MCS_CMD_GO_BIT     = 29;
  localparam int          MCS_CMD_OP_LSB     = 26;
  localparam int          MCS_CMD_PORT_LSB   = 21;
  localparam int          MCS_CMD_MMD_LSB    = 16;
  // Frame codes
  localparam logic [1:0]  MCS_ST_C45         = 2'h0;
  localparam logic [1:0]  MCS_ST_C22         = 2'h1;
  localparam logic [1:0]  MCS_OP_ADDR        = 2'h0;
  localparam logic [1:0]  MCS_OP_WRITE       = 2'h1;
  localparam logic [1:0]  MCS_OP_RDINC       = 2'h2;
  localparam logic [1:0]  MCS_OP_READ        = 2'h3;
  localparam logic [1:0]  MCS_OP_C22_READ    = 2'h2;
  localparam logic [1:0]  MCS_TA_DRIVE       = 2'h2;
  // Frame timing in management clock bits
  localparam logic [5:0]  MCS_PRE_BITS       = 6'd32;
  localparam logic [4:0]  MCS_HDR_BITS       = 5'd14;
  localparam logic [4:0]  MCS_TA_BITS        = 5'd2;
  localparam logic [4:0]  MCS_DATA_BITS      = 5'd16;
  // Internal PHY mapping facts
  localparam logic [4:0]  MCS_INT_MMD        = 5'h03;
  localparam logic [15:0] MCS_INT_EXT_VAL    = 16'h3801;
  localparam logic [15:0] MCS_INT_EXT_ADDR   = 16'hFFD0;
  localparam logic [15:0] MCS_BLK_STRIDE     = 16'h0010;
  localparam logic [15:0] MCS_BLK_AN_CTRL    = 16'h0000;
  localparam logic [15:0] MCS_BLK_AN_ADV     = 16'h0010;
  localparam logic [15:0] MCS_BLK_VENDOR     = 16'h8000;
  // Poll gap in core cycles
  localparam logic [15:0] MCS_POLL_GAP       = 16'h0FFF;
  localparam logic [4:0]  MCS_POLL_REG       = 5'h01;
  localparam int          MCS_LINK_BIT       = 2;
  typedef enum logic [1:0] {MCS_SRC_NONE, MCS_SRC_CMD, MCS_SRC_POLL} mcs_src_t;
endpackage

// *** src/mcs_frame_engine.sv ***
// Serial frame engine: shifts one management frame on MDC/MDIO
`timescale 1ns/1ps
`default_nettype none
module mcs_frame_engine
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic        clause45,
  input  wire logic        short_pre,
  input  wire logic [1:0]  opcode,
  input  wire logic [4:0]  port,
  input  wire logic [4:0]  mmd,
  input  wire logic [15:0] wdata,
  input  wire logic [5:0]  divider,
  input  wire logic        mdio_in,
  output logic             mdc,
  output logic             mdio_out,
  output logic             mdio_oe,
  output logic             done,
  output logic [15:0]      rdata
);
  import mcs_pkg::*;

  logic [5:0]  div_r, div_nxt;
  logic        mdc_r, mdc_nxt;
  logic        busy_r, busy_nxt;
  logic [6:0]  bit_r, bit_nxt;
  logic [6:0]  total_r, total_nxt;
  logic [63:0] sh_r, sh_nxt;
  logic [63:0] drv_r, drv_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic        done_r, done_nxt;
  logic        rise, fall;

  // Edges of the divided clock; half period is divider+1 core cycles
  assign fall = busy_r && mdc_r && (div_r == divider);
  assign rise = busy_r && !mdc_r && (div_r == divider);

  // Frame build, shift on falling edge, sample on rising edge
  always_comb
  begin
    div_nxt   = div_r;
    mdc_nxt   = mdc_r;
    busy_nxt  = busy_r;
    bit_nxt   = bit_r;
    total_nxt = total_r;
    sh_nxt    = sh_r;
    drv_nxt   = drv_r;
    rd_nxt    = rd_r;
    done_nxt  = 1'b0;
    if (!busy_r && start)
    begin
      busy_nxt = 1'b1;
      div_nxt  = 6'h00;
      mdc_nxt  = 1'b0;
      bit_nxt  = 7'd0;
      // Preamble, start, opcode, port, mmd, turnaround, data
      sh_nxt = {32'hFFFF_FFFF, clause45 ? MCS_ST_C45 : MCS_ST_C22,
                opcode, port, mmd, MCS_TA_DRIVE, wdata};
      // Read frames release the line after the mmd field
      drv_nxt = opcode[1] ? {46'h3FFF_FFFF_FFFF, 18'h00000}
                          : 64'hFFFF_FFFF_FFFF_FFFF;
      if (short_pre)
      begin
        sh_nxt  = {sh_nxt[31:0], 32'h0000_0000};
        drv_nxt = {drv_nxt[31:0], 32'h0000_0000};
        total_nxt = 7'd32;
      end
      else
        total_nxt = 7'd64;
    end
    else if (busy_r)
    begin
      div_nxt = (div_r == divider) ? 6'h00 : div_r + 6'h01;
      if (div_r == divider)
        mdc_nxt = !mdc_r;
      if (rise && bit_r >= total_r - 7'd16)
        rd_nxt = {rd_r[14:0], mdio_in};
      if (fall)
      begin
        sh_nxt  = {sh_r[62:0], 1'b0};
        drv_nxt = {drv_r[62:0], 1'b0};
        bit_nxt = bit_r + 7'd1;
        if (bit_r + 7'd1 == total_r)
        begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_r   <= 6'h00;
      mdc_r   <= 1'b0;
      busy_r  <= 1'b0;
      bit_r   <= 7'h00;
      total_r <= 7'h40;
      sh_r    <= 64'h0;
      drv_r   <= 64'h0;
      rd_r    <= 16'h0000;
      done_r  <= 1'b0;
    end
    else
    begin
      div_r   <= div_nxt;
      mdc_r   <= mdc_nxt;
      busy_r  <= busy_nxt;
      bit_r   <= bit_nxt;
      total_r <= total_nxt;
      sh_r    <= sh_nxt;
      drv_r   <= drv_nxt;
      rd_r    <= rd_nxt;
      done_r  <= done_nxt;
    end
  end

  assign mdc      = mdc_r;
  assign mdio_out = sh_r[63];
  assign mdio_oe  = busy_r && drv_r[63];
  assign done     = done_r;
  assign rdata    = rd_r;
endmodule
`default_nettype wire

// *** src/mcs_station.sv ***
// Management station top: register port, poll, pin mode, frame engine
`timescale 1ns/1ps
`default_nettype none
module mcs_station
(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic [19:0]          reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 mdio_i,
  output logic                      mdc_o,
  output logic                      mdio_o,
  output logic                      mdio_oe,
  output logic                      link_up,
  output logic      [4:0]           internal_mmd_sel
);
  import mcs_pkg::*;

  logic [31:0] mode_r, mode_nxt;
  logic [31:0] cmd_r, cmd_nxt;
  logic [31:0] sel_r, sel_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        link_r, link_nxt;
  logic [15:0] gap_r, gap_nxt;
  mcs_src_t    src_r, src_nxt;
  logic        start_r, start_nxt;
  logic        mdc_r, mdo_r, oe_r;
  logic        sync1_r, sync2_r;
  logic        eng_mdc, eng_out, eng_oe, eng_done;
  logic [15:0] eng_rdata;
  logic        bang, c45, poll_en;
  logic [1:0]  eng_op;
  logic [4:0]  eng_mmd;

  assign bang    = mode_r[MCS_MODE_BANG_BIT];
  assign c45     = mode_r[MCS_MODE_C45_BIT];
  assign poll_en = mode_r[MCS_MODE_POLL_BIT];
  // Poll frames reuse the command port field and read the status register
  assign eng_op  = (src_r == MCS_SRC_POLL) ? MCS_OP_C22_READ
                                           : cmd_r[27:26];
  assign eng_mmd = (src_r == MCS_SRC_POLL) ? MCS_POLL_REG
                                           : cmd_r[20:16];

  // Two-stage synchroniser on the MDIO pin
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end
    else
    begin
      sync1_r <= mdio_i;
      sync2_r <= sync1_r;
    end
  end

  mcs_frame_engine u_eng
  (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .start     (start_r),
    .clause45  (src_r == MCS_SRC_POLL ? 1'b0 : c45),
    .short_pre (src_r == MCS_SRC_POLL ? mode_r[1] : 1'b0),
    .opcode    (eng_op),
    .port      (cmd_r[25:21]),
    .mmd       (eng_mmd),
    .wdata     (cmd_r[15:0]),
    .divider   (mode_r[21:16]),
    .mdio_in   (sync2_r),
    .mdc       (eng_mdc),
    .mdio_out  (eng_out),
    .mdio_oe   (eng_oe),
    .done      (eng_done),
    .rdata     (eng_rdata)
  );

  // Register writes, command launch, poll arbitration and read mux
  always_comb
  begin
    mode_nxt  = mode_r;
    cmd_nxt   = cmd_r;
    sel_nxt   = sel_r;
    link_nxt  = link_r;
    gap_nxt   = gap_r;
    src_nxt   = src_r;
    start_nxt = 1'b0;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr)
    begin
      case (reg_addr)
        MCS_OFF_MODE:
        begin
          mode_nxt = reg_wdata & 32'h803F_0F12;
          // A zero divider is invalid; keep the old one
          if (reg_wdata[21:16] == 6'h00)
            mode_nxt[21:16] = mode_r[21:16];
        end
        MCS_OFF_COMMAND:
          if (!bang && src_r == MCS_SRC_NONE)
            cmd_nxt = reg_wdata & 32'h3FFF_FFFF;
        MCS_OFF_MMDSEL: sel_nxt = {27'h0, reg_wdata[4:0]};
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        MCS_OFF_MODE:
          rdata_nxt = {mode_r[31:10], sync2_r, mode_r[8:0]};
        MCS_OFF_COMMAND: rdata_nxt = bang ? 32'h0 : cmd_r;
        MCS_OFF_MMDSEL:  rdata_nxt = sel_r;
        MCS_OFF_POLL:    rdata_nxt = {31'h0, link_r};
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
    // Arbiter: command first, polling only while nothing else runs
    case (src_r)
      MCS_SRC_NONE:
      begin
        if (cmd_r[MCS_CMD_GO_BIT] && !bang)
        begin
          src_nxt   = MCS_SRC_CMD;
          start_nxt = 1'b1;
        end
        else if (poll_en && !bang)
        begin
          gap_nxt = gap_r + 16'h0001;
          if (gap_r == MCS_POLL_GAP)
          begin
            gap_nxt   = 16'h0000;
            src_nxt   = MCS_SRC_POLL;
            start_nxt = 1'b1;
          end
        end
        else
          gap_nxt = 16'h0000;
      end
      MCS_SRC_CMD:
        if (eng_done)
        begin
          src_nxt = MCS_SRC_NONE;
          cmd_nxt[MCS_CMD_GO_BIT] = 1'b0;
          if (cmd_r[27])
            cmd_nxt[15:0] = eng_rdata;
        end
      MCS_SRC_POLL:
        if (eng_done)
        begin
          src_nxt  = MCS_SRC_NONE;
          link_nxt = eng_rdata[MCS_LINK_BIT];
        end
      default: src_nxt = MCS_SRC_NONE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r  <= {10'h0, MCS_DIV_RST, 16'h0000};
      cmd_r   <= 32'h0000_0000;
      sel_r   <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
      link_r  <= 1'b0;
      gap_r   <= 16'h0000;
      src_r   <= MCS_SRC_NONE;
      start_r <= 1'b0;
    end
    else
    begin
      mode_r  <= mode_nxt;
      cmd_r   <= cmd_nxt;
      sel_r   <= sel_nxt;
      rdata_r <= rdata_nxt;
      link_r  <= link_nxt;
      gap_r   <= gap_nxt;
      src_r   <= src_nxt;
      start_r <= start_nxt;
    end
  end

  // Pin drivers registered; pin mode overrides the engine
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mdc_r <= 1'b0;
      mdo_r <= 1'b1;
      oe_r  <= 1'b0;
    end
    else if (bang)
    begin
      mdc_r <= mode_r[MCS_MODE_MDC_BIT];
      mdo_r <= mode_r[MCS_MODE_IO_BIT];
      oe_r  <= mode_r[MCS_MODE_OE_BIT];
    end
    else
    begin
      mdc_r <= eng_mdc;
      mdo_r <= eng_out;
      oe_r  <= eng_oe;
    end
  end

  assign reg_rdata        = rdata_r;
  assign mdc_o            = mdc_r;
  assign mdio_o           = mdo_r;
  assign mdio_oe          = oe_r;
  assign link_up          = link_r;
  assign internal_mmd_sel = sel_r[4:0];
endmodule
`default_nettype wire

// *** test/mcs_station_monitor.sv ***
// Checker bound to the station's register port and serial pins
`timescale 1ns/1ps
`default_nettype none
module mcs_monitor
  import mcs_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [19:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        mdc_o,
  input wire logic        mdio_o,
  input wire logic        mdio_oe
);
  logic [5:0] div_r;
  logic [6:0] bits_r;
  logic [6:0] hc_r;
  logic       bang_r;
  logic       c45_r;
  logic       rdop_r;
  logic       rdq_r;
  wire logic  mw = reg_wr && reg_addr == MCS_OFF_MODE;
  wire logic  cw = reg_wr && reg_addr == MCS_OFF_COMMAND && reg_wdata[29];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Mode shadow, bit index in frame, cycles since the last MDC edge
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      div_r  <= MCS_DIV_RST;
      bang_r <= 1'b0;
      c45_r  <= 1'b0;
      rdop_r <= 1'b0;
      rdq_r  <= 1'b0;
      bits_r <= 7'h40;
      hc_r   <= 7'h0;
    end
    else
    begin
      rdq_r <= reg_rd;
      hc_r  <= $changed(mdc_o) ? 7'h0 : hc_r + {6'h0, hc_r != 7'h7F};
      // A zero divider is refused, so the shadow keeps the old one
      if (mw && reg_wdata[21:16] != 6'h0)
        div_r <= reg_wdata[21:16];
      if (mw)
        {c45_r, bang_r} <= {reg_wdata[31], reg_wdata[8]};
      if (cw && !bang_r && bits_r == 7'h40)
      begin
        bits_r <= 7'h0;
        rdop_r <= reg_wdata[27];
      end
      else if ($rose(mdc_o) && bits_r != 7'h40)
        bits_r <= bits_r + 7'h1;
    end
  chk_rdata_quiet: assert property (!rdq_r |-> reg_rdata == 32'h0)
    else $error("read data outside its answer cycle");
  chk_bang_read: assert property (rdq_r && bang_r &&
    $past(reg_addr) == MCS_OFF_COMMAND |-> reg_rdata == 32'h0)
    else $error("command readable in pin mode");
  chk_high_phase: assert property ($fell(mdc_o) |-> hc_r == {1'b0, div_r})
    else $error("clock high phase length");
  chk_low_phase: assert property ($rose(mdc_o) |-> hc_r >= {1'b0, div_r})
    else $error("clock low phase too short");
  chk_go_start: assert property (cw && !bang_r && bits_r == 7'h40
    |-> ##[1:200] $rose(mdc_o))
    else $error("go bit did not start a frame");
  chk_preamble_ones: assert property ($rose(mdc_o) && bits_r < 7'd32
    |-> mdio_o && mdio_oe)
    else $error("preamble bit not a driven one");
  chk_start_code: assert property ($rose(mdc_o) && c45_r &&
    bits_r[6:1] == 6'd16 |-> !mdio_o)
    else $error("start code not zero");
  chk_read_release: assert property ($rose(mdc_o) && rdop_r &&
    bits_r >= 7'd46 && bits_r < 7'd64 |-> !mdio_oe)
    else $error("line driven during read data");
  cp_frame: cover property ($rose(mdc_o) && bits_r == 7'd63);
  cp_read: cover property (rdop_r && bits_r == 7'd63);
  cp_bang: cover property (rdq_r && bang_r);
endmodule
bind mcs_station mcs_monitor u_mon
(
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mdc_o(mdc_o), .mdio_o(mdio_o),
  .mdio_oe(mdio_oe)
);
`default_nettype wire

// *** test/mcs_phy_model.sv ***
// Behavioural management device on the far side of the serial pins
`timescale 1ns/1ps
`default_nettype none
module mcs_phy_model
(
  input  wire logic   resetn,
  input  wire logic   mdc,
  input  wire logic   line,
  output logic        drv_oe,
  output logic        drv_d,
  output logic [63:0] frame
);
  logic [62:0] sr;
  logic [6:0]  cnt;
  logic [15:0] addr_r;
  // Register contents are the inverted address, easy to predict
  wire logic [15:0] rdv = ~addr_r;
  // Bits enter on the rising clock; a frame is 64 bits long
  always @(posedge mdc or negedge resetn)
    if (!resetn)
    begin
      cnt    <= 7'h0;
      addr_r <= 16'h0;
      frame  <= 64'h0;
    end
    else if (cnt == 7'd63)
    begin
      cnt   <= 7'h0;
      frame <= {sr, line};
      if (sr[28:27] == 2'h0)
        addr_r <= {sr[14:0], line};
      else if (sr[28:27] == 2'h2)
        addr_r <= addr_r + 16'h1;
    end
    else
    begin
      sr  <= {sr[61:0], line};
      cnt <= cnt + 7'h1;
    end
  // Second turnaround bit low, then data MSB first; released after the frame
  always @(negedge mdc or negedge resetn)
    if (!resetn)
      drv_oe <= 1'b0;
    else if (cnt >= 7'd47 && sr[cnt - 7'd35])
    begin
      drv_oe <= 1'b1;
      drv_d  <= (cnt == 7'd47) ? 1'b0 : rdv[7'd63 - cnt];
    end
    else
      drv_oe <= 1'b0;
endmodule
`default_nettype wire

// *** test/tb_mdio_clause45_command_station.sv ***
// Self-checking bench for the management command station
`timescale 1ns/1ps
`default_nettype none
module tb_mdio_clause45_command_station
  import mcs_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        resetn;
  logic [19:0] reg_addr = 20'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        mdc_o, mdio_o, mdio_oe, p_oe, p_d, link;
  logic [63:0] frame;
  logic [4:0]  mmd_sel;
  int          miscompares = 0;
  int          num_checks = 0;
  // Shared data line has a pull-up when nobody drives it
  wire logic   line = mdio_oe ? mdio_o : (p_oe ? p_d : 1'b1);
  always #25 sys_clk = ~sys_clk;
  mcs_station dut
  (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mdio_i(line), .mdc_o(mdc_o),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .link_up(link),
    .internal_mmd_sel(mmd_sel)
  );
  mcs_phy_model phy
  (
    .resetn(resetn), .mdc(mdc_o), .line(line), .drv_oe(p_oe),
    .drv_d(p_d), .frame(frame)
  );
  task automatic report_and_stop;
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [19:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  function automatic logic [31:0] cmd(input logic [1:0] op,
                                      input logic [15:0] d);
    return {3'h1, 1'b0, op, 5'h01, MCS_INT_MMD, d};
  endfunction
  // Poll the go bit; a frame lasts about 520 cycles here
  task automatic wait_go(output logic [31:0] d);
    for (int i = 0; i < 400; i++)
    begin
      rd(MCS_OFF_COMMAND, d);
      if (d[29] === 1'b0)
        return;
    end
    miscompares++;
    report_and_stop;
  endtask
  task automatic t_reset;
    logic [31:0] d;
    rd(MCS_OFF_MODE, d);
    chk(d & 32'h803F0100, 32'h00130000);
    rd(MCS_OFF_COMMAND, d);
    chk({31'h0, d[29]}, 32'h0);
    chk({31'h0, link}, 32'h0);
    wr(MCS_OFF_MMDSEL, {27'h0, MCS_INT_MMD});
    rd(MCS_OFF_MMDSEL, d);
    chk(d & 32'h1F, 32'h3);
    chk({27'h0, mmd_sel}, 32'h3);
  endtask
  task automatic t_frame(input logic [1:0] op, input logic [15:0] di,
                         input logic [15:0] de);
    logic [31:0] d;
    wr(MCS_OFF_COMMAND, cmd(op, di));
    rd(MCS_OFF_COMMAND, d);
    chk({31'h0, d[29]}, 32'h1);
    wait_go(d);
    chk(frame[63:32], 32'hFFFFFFFF);
    chk(frame[31:0], {MCS_ST_C45, op, 5'h01, MCS_INT_MMD, 2'h2, de});
    if (op[1])
      chk({16'h0, d[15:0]}, {16'h0, de});
  endtask
  // A command written while a frame runs is dropped
  task automatic t_busy;
    logic [31:0] d;
    wr(MCS_OFF_COMMAND, cmd(MCS_OP_ADDR, MCS_BLK_AN_ADV));
    wr(MCS_OFF_COMMAND, cmd(MCS_OP_ADDR, 16'h0020));
    wait_go(d);
    chk({16'h0, frame[15:0]}, {16'h0, MCS_BLK_AN_ADV});
  endtask
  task automatic t_bang;
    logic [31:0] d;
    wr(MCS_OFF_MODE, 32'h80030100);
    rd(MCS_OFF_COMMAND, d);
    chk(d, 32'h0);
    wr(MCS_OFF_COMMAND, cmd(MCS_OP_ADDR, 16'h0777));
    rd(MCS_OFF_MODE, d);
    chk({31'h0, d[9]}, 32'h1);
    wr(MCS_OFF_MODE, 32'h80000000);
    rd(MCS_OFF_COMMAND, d);
    chk(d, cmd(MCS_OP_READ, 16'hFFEF) & 32'hDFFF_FFFF);
    rd(MCS_OFF_MODE, d);
    chk({26'h0, d[21:16]}, 32'h3);
  endtask
  // Polling fills the idle gap and reports bit two of the status word
  task automatic t_poll;
    logic [31:0] d;
    wr(MCS_OFF_MODE, 32'h80030010);
    for (int i = 0; i < 2000; i++)
    begin
      rd(MCS_OFF_POLL, d);
      if (d === 32'h1)
      begin
        chk({31'h0, link}, 32'h1);
        wr(MCS_OFF_MODE, 32'h80030000);
        return;
      end
    end
    miscompares++;
    report_and_stop;
  endtask
  initial
  begin
    resetn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    // Divider three: faster clocks outrun the synchronised read path
    wr(MCS_OFF_MODE, 32'h80030000);
    t_frame(MCS_OP_ADDR, 16'h8010, 16'h8010);
    t_frame(MCS_OP_WRITE, 16'h1234, 16'h1234);
    t_frame(MCS_OP_RDINC, 16'h0, ~16'h8010);
    t_frame(MCS_OP_READ, 16'h0, ~16'h8011);
    t_busy;
    t_frame(MCS_OP_READ, 16'h0, 16'hFFEF);
    t_bang;
    t_poll;
    t_frame(MCS_OP_WRITE, 16'hA5C3, 16'hA5C3);
    report_and_stop;
  end
endmodule
`default_nettype wire
